// >>> vlf_pkg.sv
// Register map, field layout, reset values and lookups for the oscillator and loop filter bank
package vlf_pkg;

    localparam int          ADDR_W          = 10;
    localparam int          DATA_W          = 8;

    localparam logic [9:0]  ADDR_OSC_CTL    = 10'h0F3;
    localparam logic [9:0]  ADDR_DIV_CTL    = 10'h0F4;
    localparam logic [9:0]  ADDR_FILT_CTL   = 10'h0F5;
    localparam logic [9:0]  ADDR_FILT_BYP   = 10'h0F6;

    // Oscillator control fields
    localparam int          BIT_FORCE_REL   = 4;
    localparam int          BIT_OSC_RSVD3   = 3;
    localparam int          BIT_FORCE_MID   = 2;
    localparam int          BIT_CAL         = 1;
    // Divider control fields
    localparam int          BIT_DIV_PD      = 3;
    localparam int          DIV_LSB         = 0;
    localparam int          DIV_W           = 3;
    // Loop filter fields
    localparam int          POLE_LSB        = 6;
    localparam int          POLE_W          = 2;
    localparam int          ZERO_LSB        = 3;
    localparam int          ZERO_W          = 3;
    localparam int          BIT_BYPASS      = 0;

    localparam logic [3:0]  DIV_BASE        = 4'h4;

    localparam logic        RST_FORCE_REL   = 1'b0;
    localparam logic        RST_FORCE_MID   = 1'b0;
    localparam logic        RST_CAL         = 1'b0;
    localparam logic        RST_DIV_PD      = 1'b0;
    localparam logic [2:0]  RST_DIV_CODE    = 3'h0;
    localparam logic [1:0]  RST_POLE_CODE   = 2'h0;
    localparam logic [2:0]  RST_ZERO_CODE   = 3'h0;
    localparam logic        RST_BYPASS      = 1'b0;
    localparam logic [7:0]  RD_UNMAPPED     = 8'h00;

    // Number of flops in the lock synchroniser
    localparam int          SYNC_STAGES     = 2;

    typedef struct packed {
        logic              wr;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] data;
    } vlf_req_t;

    typedef struct packed {
        logic [9:0]  second_pole_ohms;
        logic [11:0] rzero_ohms;
        logic        rzero_bypass;
    } vlf_filt_t;

    function automatic logic [9:0] vlf_pole_ohms(input logic [1:0] code);
        logic [9:0] r;
        r = 10'h384;
        unique case (code)
            2'h0: r = 10'h384;
            2'h1: r = 10'h1C2;
            2'h2: r = 10'h12C;
            2'h3: r = 10'h0E1;
        endcase
        return r;
    endfunction

    function automatic logic [11:0] vlf_zero_ohms(input logic [2:0] code, input logic byp);
        logic [11:0] r;
        r = 12'hCB2;
        unique case (code)
            3'h0: r = 12'hCB2;
            3'h1: r = 12'hABE;
            3'h2: r = 12'h8CA;
            3'h3: r = 12'h834;
            3'h4: r = 12'hBB8;
            3'h5: r = 12'h9C4;
            3'h6: r = 12'h7D0;
            3'h7: r = 12'h73A;
        endcase
        if (byp) begin
            r = 12'h000;
        end
        return r;
    endfunction

endpackage

// >>> vlf_sync_release.sv
// Lock synchroniser and distribution sync release
`timescale 1ns/100ps
module vlf_sync_release
    import vlf_pkg::*;
(
    input  wire logic mclk,
    input  wire logic srst,
    input  wire logic lock_async,
    input  wire logic force_release,
    output logic      hold
);
    logic [SYNC_STAGES-1:0] lock_sync_ff;
    logic                   hold_ff;
    logic                   nxt_hold;

    assign nxt_hold = !(force_release || lock_sync_ff[SYNC_STAGES-1]);
    assign hold     = hold_ff;

    always_ff @(posedge mclk) begin
        if (srst) begin
            lock_sync_ff <= '0;
            hold_ff      <= 1'b1;
        end else begin
            lock_sync_ff <= {lock_sync_ff[SYNC_STAGES-2:0], lock_async};
            hold_ff      <= nxt_hold;
        end
    end

    property p_hold_unlocked;
        @(posedge mclk) disable iff (srst)
        (!$past(force_release) && !$past(lock_async, 3) && !$past(srst, 3)) |-> hold_ff;
    endproperty
    a_hold_unlocked: assert property (p_hold_unlocked) else $error("Held sync released while unlocked");

    property p_release_locked;
        @(posedge mclk) disable iff (srst)
        ($past(lock_async, 3) && !$past(srst, 3) && !$past(srst, 2) && !$past(srst))
            |-> !hold_ff;
    endproperty
    a_release_locked: assert property (p_release_locked) else $error("Sync not released on lock");

    property p_force_release;
        @(posedge mclk) disable iff (srst)
        force_release |=> !hold_ff;
    endproperty
    a_force_release: assert property (p_force_release) else $error("Override did not release sync");

    c_lock_release: cover property (@(posedge mclk) disable iff (srst) hold_ff ##1 !hold_ff);
endmodule

// >>> vlf_ctrl.sv
// Oscillator, post-divider and loop filter control register bank
`timescale 1ns/100ps
module vlf_ctrl
    import vlf_pkg::*;
(
    input  wire logic        mclk,
    input  wire logic        srst,
    input  wire vlf_req_t    reg_req,
    output logic [7:0]       reg_rd_data,
    input  wire logic        out_loop_locked,
    output logic             dist_sync_hold,
    output logic             osc_force_mid,
    output logic             osc_cal_enable,
    output logic             osc_cal_start,
    output logic             post_div_pd,
    output logic [3:0]       post_div_ratio,
    output vlf_filt_t        filt
);
    logic        force_rel_ff;
    logic        force_mid_ff;
    logic        cal_ff;
    logic        cal_start_ff;
    logic        div_pd_ff;
    logic [2:0]  div_code_ff;
    logic [3:0]  div_ratio_ff;
    logic [1:0]  pole_code_ff;
    logic [2:0]  zero_code_ff;
    logic        bypass_ff;
    vlf_filt_t   filt_ff;
    logic [7:0]  rd_data_ff;

    logic        wr_osc;
    logic        wr_div;
    logic        wr_filt;
    logic        wr_byp;
    logic        nxt_cal;
    logic [3:0]  nxt_div_ratio;
    vlf_filt_t   nxt_filt;
    logic [7:0]  rd_osc;
    logic [7:0]  rd_div;
    logic [7:0]  rd_filt;
    logic [7:0]  rd_byp;
    logic [7:0]  nxt_rd_data;

    // Address decode
    assign wr_osc  = reg_req.wr && (reg_req.addr == ADDR_OSC_CTL);
    assign wr_div  = reg_req.wr && (reg_req.addr == ADDR_DIV_CTL);
    assign wr_filt = reg_req.wr && (reg_req.addr == ADDR_FILT_CTL);
    assign wr_byp  = reg_req.wr && (reg_req.addr == ADDR_FILT_BYP);

    // Calibrate bit is only changed by software
    assign nxt_cal = wr_osc ? reg_req.data[BIT_CAL] : cal_ff;

    assign nxt_div_ratio = {1'b0, div_code_ff} + DIV_BASE;

    assign nxt_filt.second_pole_ohms = vlf_pole_ohms(pole_code_ff);
    assign nxt_filt.rzero_ohms       = vlf_zero_ohms(zero_code_ff, bypass_ff);
    assign nxt_filt.rzero_bypass     = bypass_ff;

    // Readback packs only implemented bits, the rest stay zero
    assign rd_osc  = {3'h0, force_rel_ff, 1'b0, force_mid_ff, cal_ff, 1'b0};
    assign rd_div  = {4'h0, div_pd_ff, div_code_ff};
    assign rd_filt = {pole_code_ff, zero_code_ff, 3'h0};
    assign rd_byp  = {7'h00, bypass_ff};

    assign nxt_rd_data = (reg_req.addr == ADDR_OSC_CTL)  ? rd_osc  :
                         (reg_req.addr == ADDR_DIV_CTL)  ? rd_div  :
                         (reg_req.addr == ADDR_FILT_CTL) ? rd_filt :
                         (reg_req.addr == ADDR_FILT_BYP) ? rd_byp  : RD_UNMAPPED;

    always_ff @(posedge mclk) begin
        if (srst) begin
            force_rel_ff <= RST_FORCE_REL;
            force_mid_ff <= RST_FORCE_MID;
            cal_ff       <= RST_CAL;
            cal_start_ff <= 1'b0;
        end else begin
            if (wr_osc) begin
                force_rel_ff <= reg_req.data[BIT_FORCE_REL];
                force_mid_ff <= reg_req.data[BIT_FORCE_MID];
            end
            cal_ff       <= nxt_cal;
            cal_start_ff <= nxt_cal && !cal_ff;
        end
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            div_pd_ff    <= RST_DIV_PD;
            div_code_ff  <= RST_DIV_CODE;
            div_ratio_ff <= RST_DIV_CODE + DIV_BASE;
        end else begin
            if (wr_div) begin
                div_pd_ff   <= reg_req.data[BIT_DIV_PD];
                div_code_ff <= reg_req.data[DIV_LSB +: DIV_W];
            end
            div_ratio_ff <= nxt_div_ratio;
        end
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            pole_code_ff <= RST_POLE_CODE;
            zero_code_ff <= RST_ZERO_CODE;
            bypass_ff    <= RST_BYPASS;
            filt_ff      <= '0;
            rd_data_ff   <= RD_UNMAPPED;
        end else begin
            if (wr_filt) begin
                pole_code_ff <= reg_req.data[POLE_LSB +: POLE_W];
                zero_code_ff <= reg_req.data[ZERO_LSB +: ZERO_W];
            end
            if (wr_byp) begin
                bypass_ff <= reg_req.data[BIT_BYPASS];
            end
            filt_ff    <= nxt_filt;
            rd_data_ff <= nxt_rd_data;
        end
    end

    vlf_sync_release u_release (
        .mclk          (mclk),
        .srst          (srst),
        .lock_async    (out_loop_locked),
        .force_release (force_rel_ff),
        .hold          (dist_sync_hold)
    );

    assign reg_rd_data    = rd_data_ff;
    assign osc_force_mid  = force_mid_ff;
    assign osc_cal_enable = cal_ff;
    assign osc_cal_start  = cal_start_ff;
    assign post_div_pd    = div_pd_ff;
    assign post_div_ratio = div_ratio_ff;
    assign filt           = filt_ff;

    property p_force_mid;
        @(posedge mclk) disable iff (srst)
        wr_osc |=> (osc_force_mid == $past(reg_req.data[BIT_FORCE_MID]));
    endproperty
    a_force_mid: assert property (p_force_mid) else $error("Midpoint bit not taken");

    property p_cal_sticky;
        @(posedge mclk) disable iff (srst)
        (cal_ff && !wr_osc) |=> cal_ff;
    endproperty
    a_cal_sticky: assert property (p_cal_sticky) else $error("Calibrate bit cleared by hardware");

    property p_cal_start;
        @(posedge mclk) disable iff (srst)
        (wr_osc && reg_req.data[BIT_CAL] && !cal_ff) |-> ##1 osc_cal_start ##1 !osc_cal_start;
    endproperty
    a_cal_start: assert property (p_cal_start) else $error("Calibration start pulse wrong");

    property p_div_pd;
        @(posedge mclk) disable iff (srst)
        wr_div |=> (post_div_pd == $past(reg_req.data[BIT_DIV_PD]));
    endproperty
    a_div_pd: assert property (p_div_pd) else $error("Post-divider power-down not taken");

    property p_div_ratio;
        @(posedge mclk) disable iff (srst)
        (wr_div && !$past(srst)) ##1 !wr_div |=>
            (post_div_ratio == {1'b0, $past(reg_req.data[2:0], 2)} + DIV_BASE);
    endproperty
    a_div_ratio: assert property (p_div_ratio) else $error("Post-divider ratio wrong");

    property p_pole;
        @(posedge mclk) disable iff (srst)
        (wr_filt && reg_req.data[7:6] == 2'h3) ##1 !wr_filt
            |=> (filt.second_pole_ohms == 10'h0E1);
    endproperty
    a_pole: assert property (p_pole) else $error("Pole resistor lookup wrong");

    property p_zero;
        @(posedge mclk) disable iff (srst)
        (!bypass_ff && zero_code_ff == 3'h1) ##1 (!bypass_ff && zero_code_ff == 3'h1)
            |=> (filt.rzero_ohms == 12'hABE);
    endproperty
    a_zero: assert property (p_zero) else $error("Zero resistor lookup wrong");

    property p_bypass;
        @(posedge mclk) disable iff (srst)
        bypass_ff |=> (filt.rzero_ohms == 12'h000 && filt.rzero_bypass);
    endproperty
    a_bypass: assert property (p_bypass) else $error("Bypass did not short zero resistor");

    property p_rsvd_zero;
        @(posedge mclk) disable iff (srst)
        (reg_req.addr == ADDR_OSC_CTL) |=> (reg_rd_data[7:5] == 3'h0 && reg_rd_data[3] == 1'b0
                                            && reg_rd_data[0] == 1'b0);
    endproperty
    a_rsvd_zero: assert property (p_rsvd_zero) else $error("Reserved bits read nonzero");

    property p_force_rel;
        @(posedge mclk) disable iff (srst)
        wr_osc |=> (force_rel_ff == $past(reg_req.data[BIT_FORCE_REL]));
    endproperty
    a_force_rel: assert property (p_force_rel) else $error("Release override bit not taken");

    property p_cal_clear;
        @(posedge mclk) disable iff (srst)
        (wr_osc && !reg_req.data[BIT_CAL]) |=> (!osc_cal_enable && !osc_cal_start);
    endproperty
    a_cal_clear: assert property (p_cal_clear) else $error("Calibration reset not taken");

    // Any address outside the bank must read as zero
    property p_unmapped_rd;
        @(posedge mclk) disable iff (srst)
        (reg_req.addr < ADDR_OSC_CTL || reg_req.addr > ADDR_FILT_BYP)
            |=> (reg_rd_data == RD_UNMAPPED);
    endproperty
    a_unmapped_rd: assert property (p_unmapped_rd) else $error("Unmapped read nonzero");

    c_cal: cover property (@(posedge mclk) disable iff (srst) osc_cal_start);
    c_bypass: cover property (@(posedge mclk) disable iff (srst) filt.rzero_bypass);
    c_div11: cover property (@(posedge mclk) disable iff (srst) post_div_ratio == 4'hB);
endmodule

// >>> vlf_ctrl_bench.sv
// Self-checking bench for the oscillator and loop filter control bank
`timescale 1ns/100ps
module vlf_ctrl_bench
    import vlf_pkg::*;
;
    logic        mclk;
    logic        srst;
    vlf_req_t    reg_req;
    logic [7:0]  reg_rd_data;
    logic        out_loop_locked;
    logic        dist_sync_hold;
    logic        osc_force_mid;
    logic        osc_cal_enable;
    logic        osc_cal_start;
    logic        post_div_pd;
    logic [3:0]  post_div_ratio;
    vlf_filt_t   filt;
    int          errors;
    int          total_checks;
    int          cycles = 0;
    logic [31:0] seed;
    logic [31:0] r;
    logic [9:0]  a;
    logic [7:0]  d;
    logic [7:0]  shadow [4];
    logic [7:0]  mask   [4] = '{8'h16, 8'h0F, 8'hF8, 8'h01};
    logic [9:0]  amap   [4] = '{ADDR_OSC_CTL, ADDR_DIV_CTL, ADDR_FILT_CTL, ADDR_FILT_BYP};

    vlf_ctrl dut (.mclk(mclk), .srst(srst), .reg_req(reg_req), .reg_rd_data(reg_rd_data),
        .out_loop_locked(out_loop_locked), .dist_sync_hold(dist_sync_hold),
        .osc_force_mid(osc_force_mid), .osc_cal_enable(osc_cal_enable),
        .osc_cal_start(osc_cal_start), .post_div_pd(post_div_pd),
        .post_div_ratio(post_div_ratio), .filt(filt));

    initial begin
        mclk = 1'b0;
        forever #20 mclk = ~mclk;
    end

    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    function automatic logic [9:0] pole_ohm(input logic [1:0] c);
        logic [9:0] t [4] = '{10'h384, 10'h1C2, 10'h12C, 10'h0E1};
        return t[c];
    endfunction

    function automatic logic [11:0] zero_ohm(input logic [2:0] c);
        logic [11:0] t [8] = '{12'hCB2, 12'hABE, 12'h8CA, 12'h834,
                               12'hBB8, 12'h9C4, 12'h7D0, 12'h73A};
        return t[c];
    endfunction

    function automatic logic [7:0] map_rd(input logic [9:0] ad);
        logic [7:0] v = 8'h00;
        for (int i = 0; i < 4; i++) if (amap[i] == ad) v = shadow[i];
        return v;
    endfunction

    task automatic wrap_up();
        $display("checks %0d errors %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        total_checks++;
        if (got !== exp) begin
            errors++;
            $display("MISMATCH t=%0t %s got %0h exp %0h", $time, what, got, exp);
        end
    endtask

    task automatic put(input logic [9:0] ad, input logic [7:0] dt);
        @(posedge mclk);
        #2;
        reg_req = '{wr: 1'b1, addr: ad, data: dt};
        @(posedge mclk);
        #2;
        reg_req.wr = 1'b0;
        for (int i = 0; i < 4; i++) if (amap[i] == ad) shadow[i] = dt & mask[i];
    endtask

    task automatic rd(input logic [9:0] ad);
        @(posedge mclk);
        #2;
        reg_req.addr = ad;
        @(posedge mclk);
        #1;
        chk(reg_rd_data, map_rd(ad), "read back");
        #1;
    endtask

    task automatic chk_out();
        repeat (4) @(posedge mclk);
        #1;
        chk(osc_force_mid, shadow[0][BIT_FORCE_MID], "midscale");
        chk(osc_cal_enable, shadow[0][BIT_CAL], "cal level");
        chk(post_div_pd, shadow[1][BIT_DIV_PD], "div power");
        chk(post_div_ratio, {1'b0, shadow[1][2:0]} + 4'h4, "div ratio");
        chk(filt.second_pole_ohms, pole_ohm(shadow[2][7:6]), "pole ohms");
        chk(filt.rzero_ohms, shadow[3][0] ? 12'h000 : zero_ohm(shadow[2][5:3]), "zero");
        chk(filt.rzero_bypass, shadow[3][0], "bypass");
        chk(dist_sync_hold, !(shadow[0][BIT_FORCE_REL] | out_loop_locked), "hold");
        #1;
    endtask

    task automatic cal_pulse(input logic [7:0] dt, input logic [31:0] exp);
        logic [31:0] n = 0;
        put(ADDR_OSC_CTL, dt);
        // Start pulse rises at the write edge, so it already stands here
        repeat (4) begin
            if (osc_cal_start === 1'b1) n++;
            @(posedge mclk);
            #1;
        end
        chk(n, exp, "cal pulses");
    endtask

    always @(posedge mclk) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            errors++;
            $display("MISMATCH t=%0t timeout", $time);
            wrap_up();
        end
    end

    initial begin
        errors = 0;
        total_checks = 0;
        seed = 32'h000025A8;
        srst = 1'b1;
        reg_req = '0;
        out_loop_locked = 1'b0;
        shadow = '{default: 8'h00};
        repeat (5) @(posedge mclk);
        #2;
        srst = 1'b0;
        for (int i = 0; i < 4; i++) rd(amap[i]);
        chk_out();
        // Lock must travel the synchroniser before release
        out_loop_locked = 1'b1;
        @(posedge mclk);
        #1;
        chk(dist_sync_hold, 1'b1, "early release");
        chk_out();
        out_loop_locked = 1'b0;
        chk_out();
        put(ADDR_OSC_CTL, 8'h10);
        chk_out();
        put(ADDR_OSC_CTL, 8'hF7);
        rd(ADDR_OSC_CTL);
        chk_out();
        for (logic [3:0] k = 0; k < 8; k++) begin
            put(ADDR_DIV_CTL, {4'hF, k[0], k[2:0]});
            put(ADDR_FILT_CTL, {k[1:0], k[2:0], 3'h7});
            rd(ADDR_DIV_CTL);
            chk_out();
        end
        put(ADDR_FILT_BYP, 8'hFF);
        rd(ADDR_FILT_BYP);
        chk_out();
        put(ADDR_FILT_BYP, 8'h00);
        // Calibrate bit is still set from the earlier write, clear it first
        cal_pulse(8'h00, 0);
        cal_pulse(8'h02, 1);
        cal_pulse(8'h02, 0);
        cal_pulse(8'h00, 0);
        cal_pulse(8'h06, 1);
        put(10'h0F7, 8'hFF);
        rd(10'h0F7);
        for (int i = 0; i < 60; i++) begin
            r = xs();
            a = r[2] ? amap[r[1:0]] : r[25:16];
            d = r[15:8];
            if (a == ADDR_OSC_CTL) d[BIT_OSC_RSVD3] = 1'b0;
            out_loop_locked = r[30];
            put(a, d);
            rd(a);
            chk_out();
        end
        wrap_up();
    end
endmodule
